// ===== design/strs_pkg.sv
package strs_pkg;

   // ----------------------------------------------------------------
   // Command codes and status codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_RESERVE  = 8'h16;
   localparam logic [7:0] OP_RECAL    = 8'h01;
   localparam logic [7:0] OP_SEEK     = 8'h0B;
   localparam logic [7:0] ST_GOOD     = 8'h00;
   localparam logic [7:0] ST_CHECK    = 8'h02;
   localparam logic [7:0] ST_CONFLICT = 8'h18;

   // ----------------------------------------------------------------
   // Command field positions
   // ----------------------------------------------------------------
   localparam int LUN_HI     = 7;
   localparam int LUN_LO     = 5;
   localparam int TP_BIT     = 4;
   localparam int TP_ID_HI   = 3;
   localparam int TP_ID_LO   = 1;
   localparam int FLAG_BIT   = 1;
   localparam int LINK_BIT   = 0;
   localparam int SEEK_HI_HI = 4;

   // ----------------------------------------------------------------
   // Sense layout constants
   // ----------------------------------------------------------------
   localparam logic [6:0] SNS_B0_ONES   = 7'h7F;
   localparam logic [7:0] SNS_ADD_LEN   = 8'h01;
   localparam logic [3:0] SNS_CLASS_MAX = 4'h3;
   localparam logic [1:0] SNS_DONT_CARE = 2'h0;

   // Six byte command block.
   typedef struct packed {
      logic [7:0] b0;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
      logic [7:0] b5;
   } strs_cdb_t;

   // Error report fed in by the command engine.
   typedef struct packed {
      logic        addr_valid;
      logic [7:0]  segment;
      logic        length_mismatch_flag;
      logic [3:0]  key;
      logic [31:0] lba;
      logic [3:0]  error_source_class;
      logic [3:0]  error_type_code;
   } strs_err_t;

   // Nine byte vendor unique extended sense block.
   typedef struct packed {
      logic [7:0]  b0;
      logic [7:0]  b1;
      logic [7:0]  b2;
      logic [31:0] lba;
      logic [7:0]  b7;
      logic [7:0]  b8;
   } strs_sense_t;

   // Reservation entry of one logical unit.
   typedef struct packed {
      logic       held;
      logic [2:0] owner;
      logic       tp;
      logic [2:0] tp_id;
      logic [7:0] resv_id;
      logic       q_valid;
      logic [2:0] q_init;
      logic [7:0] q_resv_id;
   } strs_lun_t;

   typedef enum logic {
      S_IDLE,
      S_DRIVE
   } strs_state_t;

endpackage

// ===== design/strs_core.sv
`timescale 1ns/1ns
module strs_core #(
   parameter int  NUM_LUN     = 8,
   parameter bit  QUEUE_RESV  = 1'b1
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              cdb_valid,
   input  wire strs_pkg::strs_cdb_t cdb,
   input  wire logic [2:0]        cdb_init,
   input  wire logic              rel_valid,
   input  wire logic [2:0]        rel_init,
   input  wire logic              rel_by_id,
   input  wire logic [2:0]        rel_lun,
   input  wire logic [7:0]        rel_id,
   input  wire logic              bus_dev_reset,
   input  wire logic              drive_done,
   input  wire logic              drive_error,
   input  wire logic              defect_track,
   input  wire logic              err_valid,
   input  wire strs_pkg::strs_err_t err_in,
   output logic                   busy,
   output logic                   status_valid,
   output logic [7:0]             status_code,
   output logic                   link_next,
   output logic                   int_req,
   output logic                   disconnect,
   output logic                   reconnect,
   output logic [2:0]             reconnect_init,
   output logic [2:0]             reconnect_lun,
   output logic                   cmd_pass,
   output logic                   recal_start,
   output logic                   seek_start,
   output logic [20:0]            seek_lba,
   output logic [2:0]             drive_lun,
   output logic                   seek_deferred,
   output strs_pkg::strs_sense_t  sense,
   output logic [NUM_LUN-1:0]     lun_held
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (NUM_LUN < 1 || NUM_LUN > 8) begin : g_chk
      $error("NUM_LUN must lie between 1 and 8.");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      strs_pkg::strs_state_t              st;
      logic                               link;
      logic                               flag;
      logic [2:0]                         init;
      logic                               pend_seek;
      logic [20:0]                        pend_lba;
      logic [2:0]                         pend_lun;
      logic                               busy;
      logic                               status_valid;
      logic [7:0]                         status_code;
      logic                               link_next;
      logic                               int_req;
      logic                               disconnect;
      logic                               reconnect;
      logic [2:0]                         reconnect_init;
      logic [2:0]                         reconnect_lun;
      logic                               cmd_pass;
      logic                               recal_start;
      logic                               seek_start;
      logic [20:0]                        seek_lba;
      logic [2:0]                         drive_lun;
      strs_pkg::strs_sense_t              sense;
      strs_pkg::strs_lun_t [NUM_LUN-1:0]  tab;
   } strs_core_t;

   strs_core_t s_r;
   strs_core_t s_nxt;

   // Decoded fields of the incoming command.
   logic [2:0] c_lun;
   logic       c_tp;
   logic [2:0] c_tp_id;
   logic       c_link;
   logic       c_flag;
   logic       c_inrange;

   assign c_lun     = cdb.b1[strs_pkg::LUN_HI:strs_pkg::LUN_LO];
   assign c_tp      = cdb.b1[strs_pkg::TP_BIT];
   assign c_tp_id   = cdb.b1[strs_pkg::TP_ID_HI:strs_pkg::TP_ID_LO];
   assign c_link    = cdb.b5[strs_pkg::LINK_BIT];
   assign c_flag    = cdb.b5[strs_pkg::FLAG_BIT] & c_link;
   assign c_inrange = (32'(c_lun) < NUM_LUN);

   // Finishes a command: status always, link and interrupt on success.
   function automatic strs_core_t finish(input strs_core_t t, input logic [7:0] code);
      strs_core_t u;
      u              = t;
      u.status_valid = 1'b1;
      u.status_code  = code;
      u.link_next    = t.link & (code == strs_pkg::ST_GOOD);
      u.int_req      = t.flag & (code == strs_pkg::ST_GOOD);
      u.busy         = 1'b0;
      u.st           = strs_pkg::S_IDLE;
      return u;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       blocked;
      logic [7:0] code;
      strs_pkg::strs_lun_t e;
      blocked = 1'b0;
      code    = strs_pkg::ST_GOOD;
      e       = '0;
      s_nxt   = s_r;
      // Pulses last one cycle.
      s_nxt.status_valid = 1'b0;
      s_nxt.link_next    = 1'b0;
      s_nxt.int_req      = 1'b0;
      s_nxt.disconnect   = 1'b0;
      s_nxt.reconnect    = 1'b0;
      s_nxt.cmd_pass     = 1'b0;
      s_nxt.recal_start  = 1'b0;
      s_nxt.seek_start   = 1'b0;

      // Release by the owner, selected by unit or by identifier.
      for (int i = 0; i < NUM_LUN; i++) begin
         if (rel_valid && s_nxt.tab[i].held && s_nxt.tab[i].owner == rel_init &&
             (rel_by_id ? (s_nxt.tab[i].resv_id == rel_id) : (rel_lun == 3'(i)))) begin
            s_nxt.tab[i].held = 1'b0;
         end
         if (bus_dev_reset) begin
            s_nxt.tab[i] = '0;
         end
         // A freed unit passes to the queued request, which is reconnected.
         // The handover waits one cycle while a recalibrate completes, so that
         // the two reconnect reports never share one pulse.
         if (!s_nxt.tab[i].held && s_nxt.tab[i].q_valid && !s_nxt.reconnect &&
             !(s_r.st == strs_pkg::S_DRIVE && drive_done)) begin
            e               = '0;
            e.held          = 1'b1;
            e.owner         = s_nxt.tab[i].q_init;
            e.resv_id       = s_nxt.tab[i].q_resv_id;
            s_nxt.tab[i]    = e;
            s_nxt.reconnect = 1'b1;
            s_nxt.reconnect_init = e.owner;
            s_nxt.reconnect_lun  = 3'(i);
         end
      end

      // Drive completion of recalibrate.
      if (s_r.st == strs_pkg::S_DRIVE && drive_done) begin
         s_nxt.reconnect      = 1'b1;
         s_nxt.reconnect_init = s_r.init;
         s_nxt.reconnect_lun  = s_r.drive_lun;
         s_nxt = finish(s_nxt, drive_error ? strs_pkg::ST_CHECK : strs_pkg::ST_GOOD);
      end

      // New command.
      if (cdb_valid && s_r.st == strs_pkg::S_IDLE) begin
         s_nxt.link = c_link;
         s_nxt.flag = c_flag;
         s_nxt.init = cdb_init;
         if (!c_inrange) begin
            s_nxt = finish(s_nxt, strs_pkg::ST_CHECK);
         end else begin
            e = s_nxt.tab[c_lun];
            // Owner, or the device reserved for under third party, may use the unit.
            blocked = e.held && e.owner != cdb_init &&
                      !(e.tp && e.tp_id == cdb_init);
            if (cdb.b0 == strs_pkg::OP_RESERVE) begin
               if (e.held && e.owner == cdb_init) begin
                  code = strs_pkg::ST_GOOD;
               end else if (e.held) begin
                  // Third party units never queue; the attempt is refused.
                  if (QUEUE_RESV && !e.tp && !e.q_valid) begin
                     e.q_valid   = 1'b1;
                     e.q_init    = cdb_init;
                     e.q_resv_id = cdb.b2;
                     s_nxt.disconnect = 1'b1;
                     s_nxt.link = 1'b0;
                     s_nxt.flag = 1'b0;
                  end else begin
                     code = strs_pkg::ST_CONFLICT;
                  end
               end else begin
                  e.held    = 1'b1;
                  e.owner   = cdb_init;
                  e.tp      = c_tp;
                  e.tp_id   = c_tp ? c_tp_id : 3'h0;
                  e.resv_id = cdb.b2;
               end
               s_nxt.tab[c_lun] = e;
               if (!s_nxt.disconnect) begin
                  s_nxt = finish(s_nxt, code);
               end
            end else if (blocked) begin
               s_nxt = finish(s_nxt, strs_pkg::ST_CONFLICT);
            end else if (cdb.b0 == strs_pkg::OP_RECAL) begin
               // Byte five top bit is not looked at.
               s_nxt.recal_start = 1'b1;
               s_nxt.drive_lun   = c_lun;
               s_nxt.disconnect  = 1'b1;
               s_nxt.busy        = 1'b1;
               s_nxt.st          = strs_pkg::S_DRIVE;
            end else if (cdb.b0 == strs_pkg::OP_SEEK) begin
               if (defect_track) begin
                  s_nxt.pend_seek = 1'b1;
                  s_nxt.pend_lba  = {cdb.b1[strs_pkg::SEEK_HI_HI:0], cdb.b2, cdb.b3};
                  s_nxt.pend_lun  = c_lun;
               end else begin
                  s_nxt.seek_start = 1'b1;
                  s_nxt.seek_lba   = {cdb.b1[strs_pkg::SEEK_HI_HI:0], cdb.b2, cdb.b3};
                  s_nxt.drive_lun  = c_lun;
               end
               s_nxt = finish(s_nxt, strs_pkg::ST_GOOD);
            end else begin
               // Any other command is handed on; it releases a postponed seek.
               s_nxt.cmd_pass = 1'b1;
               if (s_r.pend_seek) begin
                  s_nxt.pend_seek  = 1'b0;
                  s_nxt.seek_start = 1'b1;
                  s_nxt.seek_lba   = s_r.pend_lba;
                  s_nxt.drive_lun  = s_r.pend_lun;
               end
               s_nxt = finish(s_nxt, strs_pkg::ST_GOOD);
            end
         end
      end

      // Sense block capture.
      if (err_valid) begin
         s_nxt.sense.b0  = {err_in.addr_valid, strs_pkg::SNS_B0_ONES};
         s_nxt.sense.b1  = err_in.segment;
         s_nxt.sense.b2  = {strs_pkg::SNS_DONT_CARE, err_in.length_mismatch_flag,
                            1'b0, err_in.key};
         s_nxt.sense.lba = err_in.lba;
         s_nxt.sense.b7  = strs_pkg::SNS_ADD_LEN;
         // Classes above three are clipped to three.
         s_nxt.sense.b8  = {(err_in.error_source_class > strs_pkg::SNS_CLASS_MAX) ?
                            strs_pkg::SNS_CLASS_MAX : err_in.error_source_class,
                            err_in.error_type_code};
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign busy           = s_r.busy;
   assign status_valid   = s_r.status_valid;
   assign status_code    = s_r.status_code;
   assign link_next      = s_r.link_next;
   assign int_req        = s_r.int_req;
   assign disconnect     = s_r.disconnect;
   assign reconnect      = s_r.reconnect;
   assign reconnect_init = s_r.reconnect_init;
   assign reconnect_lun  = s_r.reconnect_lun;
   assign cmd_pass       = s_r.cmd_pass;
   assign recal_start    = s_r.recal_start;
   assign seek_start     = s_r.seek_start;
   assign seek_lba       = s_r.seek_lba;
   assign drive_lun      = s_r.drive_lun;
   assign seek_deferred  = s_r.pend_seek;
   assign sense          = s_r.sense;

   // Held flags per unit.
   always_comb begin
      for (int i = 0; i < NUM_LUN; i++) begin
         lun_held[i] = s_r.tab[i].held;
      end
   end

endmodule

// ===== tb/strs_core_asserts.sv
`timescale 1ns/1ns
module strs_core_asserts #(
   parameter int NUM_LUN = 8
) (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  cdb_valid,
   input wire logic                  busy,
   input wire logic                  defect_track,
   input wire logic                  drive_done,
   input wire logic                  err_valid,
   input wire logic                  bus_dev_reset,
   input wire logic                  status_valid,
   input wire logic                  link_next,
   input wire logic                  int_req,
   input wire logic                  disconnect,
   input wire logic                  reconnect,
   input wire logic                  recal_start,
   input wire logic                  seek_start,
   input wire logic                  seek_deferred,
   input wire logic [7:0]            status_code,
   input wire logic [2:0]            drive_lun,
   input wire logic [20:0]           seek_lba,
   input wire logic [NUM_LUN-1:0]    lun_held,
   input wire strs_pkg::strs_cdb_t   cdb,
   input wire strs_pkg::strs_err_t   err_in,
   input wire strs_pkg::strs_sense_t sense
);
   // -------------------------------------------------------------
   // Helper logic
   // -------------------------------------------------------------
   strs_pkg::strs_cdb_t cdb_r;
   strs_pkg::strs_err_t err_r;
   wire logic go = cdb_valid && !busy && !lun_held[cdb.b1[7:5]];
   // Keeps the last command and error report for one-cycle checks.
   always_ff @(posedge clk) begin
      cdb_r <= cdb;
      err_r <= err_in;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_SEEK: assert property (go && cdb.b0 == strs_pkg::OP_SEEK && !defect_track |=>
      seek_start && status_code == strs_pkg::ST_GOOD && drive_lun == cdb_r.b1[7:5]
      && seek_lba == {cdb_r.b1[4:0], cdb_r.b2, cdb_r.b3}) else $error("seek start wrong");
   AST_DEFER: assert property (go && cdb.b0 == strs_pkg::OP_SEEK && defect_track |=>
      seek_deferred && !seek_start && status_valid) else $error("seek not postponed");
   AST_LINK: assert property (go && cdb.b0 == strs_pkg::OP_SEEK |=>
      link_next == cdb_r.b5[0] && int_req == (cdb_r.b5[0] && cdb_r.b5[1]))
      else $error("link or interrupt wrong");
   AST_RESV: assert property (go && cdb.b0 == strs_pkg::OP_RESERVE |=>
      lun_held[cdb_r.b1[7:5]] && status_valid && status_code == strs_pkg::ST_GOOD)
      else $error("reserve of free unit failed");
   AST_RECAL: assert property (go && cdb.b0 == strs_pkg::OP_RECAL |=>
      recal_start && disconnect && busy) else $error("recalibrate start wrong");
   AST_DONE: assert property (busy && drive_done |=>
      status_valid && !busy ##1 (!status_valid || $past(cdb_valid)))
      else $error("recalibrate end wrong");
   AST_BDR: assert property (bus_dev_reset && !cdb_valid && !drive_done |=>
      lun_held == '0 && !reconnect) else $error("bus reset kept reservation");
   AST_SNS_FIX: assert property (err_valid |=>
      sense.b0[6:0] == 7'h7F && sense.b7 == 8'h01 && sense.b8[7:4] ==
      ((err_r.error_source_class > 4'h3) ? 4'h3 : err_r.error_source_class))
      else $error("sense fixed fields wrong");
   AST_SNS_ERR: assert property (err_valid |=>
      sense.b0[7] == err_r.addr_valid && sense.b1 == err_r.segment && sense.lba == err_r.lba
      && sense.b2[5:0] == {err_r.length_mismatch_flag, 1'b0, err_r.key}
      && sense.b8[3:0] == err_r.error_type_code) else $error("sense error fields wrong");
endmodule

bind strs_core strs_core_asserts #(.NUM_LUN(NUM_LUN)) u_chk (.clk(clk), .rst_n(rst_n),
   .cdb_valid(cdb_valid), .busy(busy), .defect_track(defect_track), .drive_done(drive_done),
   .err_valid(err_valid), .bus_dev_reset(bus_dev_reset), .status_valid(status_valid),
   .link_next(link_next), .int_req(int_req), .disconnect(disconnect), .reconnect(reconnect),
   .recal_start(recal_start), .seek_start(seek_start), .seek_deferred(seek_deferred),
   .status_code(status_code), .drive_lun(drive_lun), .seek_lba(seek_lba),
   .lun_held(lun_held), .cdb(cdb), .err_in(err_in), .sense(sense));

// ===== tb/strs_init_model.sv
`timescale 1ns/1ns
module strs_init_model (
   input  wire logic          clk,
   output strs_pkg::strs_cdb_t cdb,
   output logic               cdb_valid,
   output logic [2:0]         cdb_init
);
   // Idle bus state at time zero.
   initial begin
      {cdb_valid, cdb, cdb_init} = '0;
   end
   // Presents one command for a single edge, then scrambles the bytes.
   task automatic issue(input logic [7:0] op, input logic [2:0] ini, input logic [7:0] b1,
                        input logic [15:0] b23, input logic [7:0] b5);
      @(negedge clk);
      cdb_valid = 1'b1;
      cdb_init = ini;
      cdb = {op, b1, b23, 8'h00, b5};
      @(negedge clk);
      cdb_valid = 1'b0;
      cdb = ~cdb;
   endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   // -------------------------------------------------------------
   // Signals and instances
   // -------------------------------------------------------------
   logic clk, rst_n, cdb_valid, rel_valid, rel_by_id, bus_dev_reset, drive_done;
   // Drive_done has the drive model below as its only driver.
   logic drive_error, defect_track, err_valid, busy, status_valid, link_next, int_req;
   logic disconnect, reconnect, cmd_pass, recal_start, seek_start, seek_deferred;
   logic [2:0] cdb_init, rel_init, rel_lun, reconnect_init, reconnect_lun, drive_lun;
   logic [7:0] rel_id, status_code, lun_held;
   logic [20:0] seek_lba;
   strs_pkg::strs_cdb_t cdb;
   strs_pkg::strs_err_t err_in;
   strs_pkg::strs_sense_t sense;
   int err_total, comparisons;
   strs_core dut (.clk(clk), .rst_n(rst_n), .cdb_valid(cdb_valid), .cdb(cdb),
      .cdb_init(cdb_init), .rel_valid(rel_valid), .rel_init(rel_init), .rel_by_id(rel_by_id),
      .rel_lun(rel_lun), .rel_id(rel_id), .bus_dev_reset(bus_dev_reset),
      .drive_done(drive_done), .drive_error(drive_error), .defect_track(defect_track),
      .err_valid(err_valid), .err_in(err_in), .busy(busy), .status_valid(status_valid),
      .status_code(status_code), .link_next(link_next), .int_req(int_req),
      .disconnect(disconnect), .reconnect(reconnect), .reconnect_init(reconnect_init),
      .reconnect_lun(reconnect_lun), .cmd_pass(cmd_pass), .recal_start(recal_start),
      .seek_start(seek_start), .seek_lba(seek_lba), .drive_lun(drive_lun),
      .seek_deferred(seek_deferred), .sense(sense), .lun_held(lun_held));
   strs_init_model u_ini (.clk(clk), .cdb(cdb), .cdb_valid(cdb_valid), .cdb_init(cdb_init));
   // Clock at 4 ns period.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Drive model answers a recalibrate five cycles later, acting on falling edges.
   initial begin
      drive_done = 1'b0;
      forever begin
         @(negedge clk);
         if (recal_start) begin
            repeat (5) @(negedge clk);
            drive_done = 1'b1;
            @(negedge clk);
            drive_done = 1'b0;
         end
      end
   end
   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // Issues one release for a single edge.
   task automatic rel(input logic [2:0] ini, input logic byid, input logic [2:0] lun,
                      input logic [7:0] id);
      @(negedge clk);
      {rel_valid, rel_init, rel_by_id, rel_lun, rel_id} = {1'b1, ini, byid, lun, id};
      @(negedge clk);
      rel_valid = 1'b0;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog cuts a hang short.
   initial begin
      #20000;
      err_total++;
      complete_run();
   end
   // -------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------
   initial begin
      {rst_n, rel_valid, rel_init, rel_by_id, rel_lun, rel_id, bus_dev_reset} = '0;
      {drive_error, defect_track, err_valid, err_in} = '0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      u_ini.issue(strs_pkg::OP_RESERVE, 3'h1, 8'h40, 16'h3300, 8'h03);
      chk("resv_status", strs_pkg::ST_GOOD, status_code);
      chk("resv_held", 8'h04, lun_held);
      chk("resv_link_int", 2'b11, {link_next, int_req});
      u_ini.issue(strs_pkg::OP_RESERVE, 3'h1, 8'h40, 16'h5A00, 8'h00);
      chk("rerserve_status", strs_pkg::ST_GOOD, status_code);
      u_ini.issue(strs_pkg::OP_SEEK, 3'h3, 8'h40, 16'h0000, 8'h00);
      chk("foreign_seek", strs_pkg::ST_CONFLICT, status_code);
      u_ini.issue(strs_pkg::OP_RESERVE, 3'h3, 8'h40, 16'h0000, 8'h00);
      chk("queue_disc", 1'b1, disconnect);
      rel(3'h1, 1'b1, 3'h0, 8'h33);
      chk("reconnect", {1'b1, 3'h3, 3'h2, 8'h04},
          {reconnect, reconnect_init, reconnect_lun, lun_held});
      @(negedge clk);
      bus_dev_reset = 1'b1;
      @(negedge clk);
      bus_dev_reset = 1'b0;
      chk("bdr_held", 8'h00, lun_held);
      $display("test reserve queue done");
      u_ini.issue(strs_pkg::OP_RESERVE, 3'h4, 8'h3A, 16'h0000, 8'h00);
      chk("tp_resv", {strs_pkg::ST_GOOD, 1'b0}, {status_code, disconnect});
      u_ini.issue(strs_pkg::OP_SEEK, 3'h5, 8'h20, 16'h0000, 8'h00);
      chk("tp_user", strs_pkg::ST_GOOD, status_code);
      u_ini.issue(strs_pkg::OP_RESERVE, 3'h6, 8'h20, 16'h0000, 8'h00);
      chk("tp_other", {strs_pkg::ST_CONFLICT, 1'b0}, {status_code, disconnect});
      rel(3'h4, 1'b0, 3'h1, 8'h00);
      chk("tp_release", 8'h00, lun_held);
      $display("test third party done");
      u_ini.issue(strs_pkg::OP_SEEK, 3'h2, 8'h1A, 16'hBCDE, 8'h80);
      chk("seek_lba", {1'b1, 21'h1ABCDE, 3'h0}, {seek_start, seek_lba, drive_lun});
      chk("seek_top_bit", 1'b0, link_next);
      defect_track = 1'b1;
      u_ini.issue(strs_pkg::OP_SEEK, 3'h2, 8'h03, 16'h0102, 8'h00);
      defect_track = 1'b0;
      chk("defer", 2'b10, {seek_deferred, seek_start});
      u_ini.issue(8'h08, 3'h2, 8'h00, 16'h0000, 8'h00);
      chk("defer_go", {2'b11, 21'h030102}, {seek_start, cmd_pass, seek_lba});
      $display("test seek done");
      u_ini.issue(strs_pkg::OP_RECAL, 3'h2, 8'h60, 16'h0000, 8'h00);
      chk("recal_start", 3'b111, {recal_start, disconnect, busy});
      for (int i = 0; i < 20 && !status_valid; i++) @(negedge clk);
      chk("recal_end", {1'b1, strs_pkg::ST_GOOD, 1'b0, 1'b1, 3'h3},
          {status_valid, status_code, busy, reconnect, reconnect_lun});
      drive_error = 1'b1;
      u_ini.issue(strs_pkg::OP_RECAL, 3'h2, 8'h60, 16'h0000, 8'h00);
      for (int i = 0; i < 20 && !status_valid; i++) @(negedge clk);
      drive_error = 1'b0;
      chk("recal_fail", {1'b1, strs_pkg::ST_CHECK}, {status_valid, status_code});
      $display("test recalibrate done");
      @(negedge clk);
      err_in = {1'b1, 8'h07, 1'b1, 4'h9, 32'h0012_3456, 4'h5, 4'hA};
      err_valid = 1'b1;
      @(negedge clk);
      err_valid = 1'b0;
      chk("sense", 72'hFF_07_29_00123456_01_3A, sense);
      $display("test sense done");
      u_ini.issue(strs_pkg::OP_RESERVE, 3'h2, 8'hA0, 16'h0000, 8'h00);
      chk("resv5_held", 8'h20, lun_held);
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      chk("hard_reset", 8'h00, lun_held);
      $display("test hard reset done");
      complete_run();
   end
endmodule
